/* File: hdl/rwd_pkg.sv */
/*
 * Constants, register map and types for the runaway watchdog timer.
 * Assumes a single 10 MHz clock and a classic Wishbone slave port.
 */
package rwd_pkg;

   // ==========================================================
   // Bus geometry
   localparam int WB_ADR_W = 8;
   localparam int WB_DAT_W = 32;

   // ==========================================================
   // Register byte offsets
   localparam logic [WB_ADR_W-1:0] ADR_RESTART    = 8'h00;
   localparam logic [WB_ADR_W-1:0] ADR_FREQ_SEL   = 8'h04;
   localparam logic [WB_ADR_W-1:0] ADR_PROC_MODE0 = 8'h08;
   localparam logic [WB_ADR_W-1:0] ADR_CLK_CTRL   = 8'h0c;
   localparam logic [WB_ADR_W-1:0] ADR_IRQ_STATUS = 8'h10;
   localparam logic [WB_ADR_W-1:0] ADR_IRQ_CLEAR  = 8'h14;
   localparam logic [WB_ADR_W-1:0] ADR_IRQ_ENABLE = 8'h18;

   // ==========================================================
   // Field positions
   localparam int FREQ_SEL_BIT     = 0;
   localparam int SW_RESET_BIT     = 3;
   localparam int CLK_SYSSEL_BIT   = 0;
   localparam int CLK_MAIN_EXT_BIT = 1;
   localparam int CLK_SUB_EXT_BIT  = 2;
   localparam int CLK_SRC_LSB      = 4;
   localparam int CLK_SRC_MSB      = 5;
   localparam int IRQ_WDT_BIT      = 0;

   // ==========================================================
   // Counter
   localparam int              CNT_W    = 12;
   localparam int              CNT_MSB  = CNT_W - 1;
   localparam logic [CNT_W-1:0] CNT_LOAD = 12'hfff;
   localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;

   // ==========================================================
   // Prescaler
   localparam int PRE_W      = 9;
   localparam int DIV8_BITS  = 3;
   localparam int DIV16_BITS = 4;
   localparam int DIV32_BITS = 5;
   localparam int DIV512_BITS = 9;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS   = 100;
   localparam int SWRST_PULSE_NS  = 1000;
   localparam int SWRST_CYCLES    = (SWRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SWRST_CNT_W     = 4;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {SRC_MAIN, SRC_MAIN_DIV8, SRC_SUB, SRC_SPARE} rwd_src_t;
   typedef enum logic [1:0] {SEL_DIV512, SEL_DIV32, SEL_DIV16, SEL_DIV8} rwd_tick_sel_t;
   typedef enum logic {ST_RUN, ST_STOPPED} rwd_stop_t;

endpackage

/* File: hdl/rwd_prescaler.sv */
/*
 * Free-running divider giving one-cycle enables at clock/8, /16, /32 and /512.
 * Assumes one clock; every divided rate is an enable pulse, never a clock.
 */
`timescale 1ns/1ns
module rwd_prescaler
   import rwd_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic rst_in,
   output logic      div8_clock_out,
   output logic      div16_clock_out,
   output logic      div32_clock_out,
   output logic      div512_clock_out
);
   logic [PRE_W-1:0] count;

   // True when the low bits of the divider are all ones
   function automatic logic low_ones(input logic [PRE_W-1:0] value, input int bits);
      logic result;
      result = 1'b1;
      for (int i = 0; i < PRE_W; i++)
         if (i < bits && !value[i])
            result = 1'b0;
      return result;
   endfunction

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         count            <= '0;
         div8_clock_out   <= 1'b0;
         div16_clock_out  <= 1'b0;
         div32_clock_out  <= 1'b0;
         div512_clock_out <= 1'b0;
      end
      else
      begin
         count            <= count + 1'b1;
         div8_clock_out   <= low_ones(count, DIV8_BITS);
         div16_clock_out  <= low_ones(count, DIV16_BITS);
         div32_clock_out  <= low_ones(count, DIV32_BITS);
         div512_clock_out <= low_ones(count, DIV512_BITS);
      end
   end
endmodule

/* File: hdl/rwd_sync.sv */
/*
 * Two flip-flop synchroniser for a group of asynchronous pin levels.
 * Assumes the inputs are slow levels; pulses shorter than one clock may be lost.
 */
`timescale 1ns/1ns
module rwd_sync #(
   parameter int WIDTH = 1
)(
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta  <= '0;
         q_out <= '0;
      end
      else
      begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule

/* File: hdl/rwd_watchdog.sv */
/*
 * Runaway watchdog timer: 12-bit down counter with clock selection,
 * interrupt status/enable/clear, software reset pulse and Wishbone slave.
 * Assumes hold and the high-voltage disable come from pins (synchronised
 * here) and that stop_instruction_in and stop_wake_in are same-clock pulses.
 */
`timescale 1ns/1ns
module rwd_watchdog
   import rwd_pkg::*;
(
   input  wire logic                         clock_in,
   input  wire logic                         rst_in,
   input  wire logic                         wb_cyc_in,
   input  wire logic                         wb_stb_in,
   input  wire logic                         wb_we_in,
   input  wire logic [rwd_pkg::WB_ADR_W-1:0] wb_adr_in,
   input  wire logic [3:0]                   wb_sel_in,
   input  wire logic [rwd_pkg::WB_DAT_W-1:0] wb_dat_in,
   output logic      [rwd_pkg::WB_DAT_W-1:0] wb_dat_out,
   output logic                              wb_ack_out,
   input  wire logic                         stop_instruction_in,
   input  wire logic                         stop_wake_in,
   input  wire logic                         hold_in,
   input  wire logic                         wdt_disable_in,
   output logic                              irq_out,
   output logic                              sw_reset_out,
   output logic                              stop_release_out
);
   import rwd_pkg::*;

   // ==========================================================
   // Declarations
   // Divided clocks and synchronised pins
   logic                   div8_tick;
   logic                   div16_tick;
   logic                   div32_tick;
   logic                   div512_tick;
   logic [1:0]             pin_sync;
   logic                   hold_sync;
   logic                   disable_sync;

   // Bus decode
   logic                   bus_req;
   logic                   bus_start;
   logic                   bus_write;
   logic                   bus_read;
   logic                   write_low;
   logic [WB_DAT_W-1:0]    read_data;

   // Counter and its clock selection
   logic [CNT_W-1:0]       count;
   logic [CNT_W-1:0]       next_count;
   logic                   count_tick;
   logic                   underflow;
   logic                   restart_wr;
   logic                   freq_sel;
   logic                   sys_clk_sel;
   logic                   main_ext_sel;
   logic                   sub_ext_sel;
   rwd_src_t               clk_src;
   rwd_tick_sel_t          tick_sel;
   logic                   tick;
   rwd_stop_t              stop_state;
   rwd_stop_t              next_stop_state;

   // Interrupt and software reset
   logic                   irq_status;
   logic                   next_irq_status;
   logic                   irq_enable;
   logic                   irq_clear;
   logic                   swrst_req;
   logic [SWRST_CNT_W-1:0] swrst_count;
   logic [SWRST_CNT_W-1:0] next_swrst_count;

   // Address decode, shared by reads and writes
   function automatic logic hit(input logic [WB_ADR_W-1:0] adr,
                                input logic [WB_ADR_W-1:0] offset);
      return adr == offset;
   endfunction

   // ==========================================================
   // Divided clocks and pin synchronisers
   rwd_prescaler u_prescaler (
      .clock_in         (clock_in),
      .rst_in           (rst_in),
      .div8_clock_out   (div8_tick),
      .div16_clock_out  (div16_tick),
      .div32_clock_out  (div32_tick),
      .div512_clock_out (div512_tick)
   );

   rwd_sync #(.WIDTH(2)) u_sync (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .d_in     ({hold_in, wdt_disable_in}),
      .q_out    (pin_sync)
   );

   // Both pins are slow levels from outside this clock; two flops before use
   assign hold_sync    = pin_sync[1];
   assign disable_sync = pin_sync[0];

   // ==========================================================
   // Wishbone slave: ack one cycle after the request, write at the ack edge
   // A request held past its ack is answered again on alternate cycles
   // rather than stalling the bus
   assign bus_req   = wb_cyc_in && wb_stb_in;
   assign bus_start = bus_req && !wb_ack_out;
   assign bus_write = bus_req && wb_we_in && wb_ack_out;
   assign bus_read  = bus_start && !wb_we_in;
   assign write_low = bus_write && wb_sel_in[0];

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         wb_ack_out <= 1'b0;
      else
         wb_ack_out <= bus_start;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         wb_dat_out <= '0;
      else if (bus_read)
         wb_dat_out <= read_data;
   end

   // Unmapped and write-only offsets read as zero
   always_comb
   begin
      read_data = '0;
      if (hit(wb_adr_in, ADR_RESTART))
         read_data[CNT_W-1:0] = count;
      else if (hit(wb_adr_in, ADR_FREQ_SEL))
         read_data[FREQ_SEL_BIT] = freq_sel;
      else if (hit(wb_adr_in, ADR_CLK_CTRL))
      begin
         read_data[CLK_SYSSEL_BIT]          = sys_clk_sel;
         read_data[CLK_MAIN_EXT_BIT]        = main_ext_sel;
         read_data[CLK_SUB_EXT_BIT]         = sub_ext_sel;
         read_data[CLK_SRC_MSB:CLK_SRC_LSB] = clk_src;
      end
      else if (hit(wb_adr_in, ADR_IRQ_STATUS))
         read_data[IRQ_WDT_BIT] = irq_status;
      else if (hit(wb_adr_in, ADR_IRQ_ENABLE))
         read_data[IRQ_WDT_BIT] = irq_enable;
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         freq_sel <= 1'b0;
      else if (write_low && hit(wb_adr_in, ADR_FREQ_SEL))
         freq_sel <= wb_dat_in[FREQ_SEL_BIT];
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sys_clk_sel  <= 1'b0;
         main_ext_sel <= 1'b0;
         sub_ext_sel  <= 1'b0;
         clk_src      <= SRC_MAIN;
      end
      else if (write_low && hit(wb_adr_in, ADR_CLK_CTRL))
      begin
         sys_clk_sel  <= wb_dat_in[CLK_SYSSEL_BIT];
         main_ext_sel <= wb_dat_in[CLK_MAIN_EXT_BIT];
         sub_ext_sel  <= wb_dat_in[CLK_SUB_EXT_BIT];
         clk_src      <= rwd_src_t'(wb_dat_in[CLK_SRC_MSB:CLK_SRC_LSB]);
      end
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         irq_enable <= 1'b0;
      else if (write_low && hit(wb_adr_in, ADR_IRQ_ENABLE))
         irq_enable <= wb_dat_in[IRQ_WDT_BIT];
   end

   // ==========================================================
   // Stop mode: entered by the stop instruction, left on a wake or on the
   // watchdog underflow, which is how the oscillator restart is timed
   always_comb
   begin
      next_stop_state = stop_state;
      case (stop_state)
         ST_RUN:
            if (stop_instruction_in)
               next_stop_state = ST_STOPPED;
         ST_STOPPED:
            if (underflow || stop_wake_in)
               next_stop_state = ST_RUN;
         default:
            next_stop_state = ST_RUN;
      endcase
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         stop_state <= ST_RUN;
      else
         stop_state <= next_stop_state;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         stop_release_out <= 1'b0;
      else
         stop_release_out <= (stop_state == ST_STOPPED) && underflow;
   end

   // ==========================================================
   // Count clock selection; external clock input outranks stop forcing
   always_comb
   begin
      if ((main_ext_sel && (clk_src == SRC_MAIN || clk_src == SRC_MAIN_DIV8)) ||
          (sub_ext_sel && clk_src == SRC_SUB))
         tick_sel = SEL_DIV16;
      else if (stop_state == ST_STOPPED || stop_instruction_in)
         tick_sel = sys_clk_sel ? SEL_DIV8 : SEL_DIV32;
      else
         tick_sel = freq_sel ? SEL_DIV32 : SEL_DIV512;
   end

   always_comb
   begin
      case (tick_sel)
         SEL_DIV512: tick = div512_tick;
         SEL_DIV32:  tick = div32_tick;
         SEL_DIV16:  tick = div16_tick;
         SEL_DIV8:   tick = div8_tick;
         default:    tick = 1'b0;
      endcase
   end

   // ==========================================================
   // Watchdog counter
   // The write data is ignored on purpose; only the access matters
   assign restart_wr = bus_write && hit(wb_adr_in, ADR_RESTART);
   // The disable level pins the counter at its load value, so it cannot expire;
   // the mask covers a low top bit seen in the cycle the pin arrives
   assign underflow  = !count[CNT_MSB] && !disable_sync;
   // Hold stops the divided clock input, so a tick during hold is lost, not delayed
   assign count_tick = tick && !hold_sync;

   always_comb
   begin
      next_count = count;
      if (stop_instruction_in || restart_wr || disable_sync)
         next_count = CNT_LOAD;
      else if (underflow)
         next_count = CNT_LOAD;
      else if (count_tick)
         next_count = count - CNT_ONE;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         count <= CNT_LOAD;
      else
         count <= next_count;
   end

   // ==========================================================
   // Interrupt status: a new underflow beats a clear in the same cycle
   assign irq_clear = write_low && hit(wb_adr_in, ADR_IRQ_CLEAR) && wb_dat_in[IRQ_WDT_BIT];

   always_comb
   begin
      next_irq_status = irq_status;
      if (underflow)
         next_irq_status = 1'b1;
      else if (irq_clear)
         next_irq_status = 1'b0;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         irq_status <= 1'b0;
      else
         irq_status <= next_irq_status;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         irq_out <= 1'b0;
      else
         irq_out <= irq_status && irq_enable;
   end

   // ==========================================================
   // Software reset pulse; the bit itself reads back as zero
   assign swrst_req = write_low && hit(wb_adr_in, ADR_PROC_MODE0) && wb_dat_in[SW_RESET_BIT];

   // Cycles of the pulse still to come; a new request restarts the count
   always_comb
   begin
      next_swrst_count = swrst_count;
      if (swrst_req)
         next_swrst_count = SWRST_CNT_W'(SWRST_CYCLES);
      else if (swrst_count != '0)
         next_swrst_count = swrst_count - 1'b1;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         swrst_count <= '0;
      else
         swrst_count <= next_swrst_count;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         sw_reset_out <= 1'b0;
      else
         sw_reset_out <= swrst_req || (swrst_count > SWRST_CNT_W'(1));
   end

endmodule

/* File: testbench/rwd_watchdog_asserts.sv */
/* Port checker for rwd_watchdog.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ns
module rwd_watchdog_asserts
   import rwd_pkg::*;
(
   input wire logic                         clock_in,
   input wire logic                         rst_in,
   input wire logic                         wb_cyc_in,
   input wire logic                         wb_stb_in,
   input wire logic                         wb_we_in,
   input wire logic [rwd_pkg::WB_ADR_W-1:0] wb_adr_in,
   input wire logic [3:0]                   wb_sel_in,
   input wire logic [rwd_pkg::WB_DAT_W-1:0] wb_dat_in,
   input wire logic [rwd_pkg::WB_DAT_W-1:0] wb_dat_out,
   input wire logic                         wb_ack_out,
   input wire logic                         irq_out,
   input wire logic                         sw_reset_out,
   input wire logic                         stop_release_out
);
   logic       wr;
   logic       rd;
   logic       irq_off;
   logic [3:0] swr_len;

   // ====
   // Helpers
   assign wr = wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in;
   assign rd = wb_ack_out && wb_cyc_in && wb_stb_in && !wb_we_in;
   assign irq_off = wr && wb_sel_in[0] && ((wb_adr_in == ADR_IRQ_CLEAR && wb_dat_in[0])
                    || (wb_adr_in == ADR_IRQ_ENABLE && !wb_dat_in[0]));

   // Length of the current software reset pulse
   always_ff @(posedge clock_in or posedge rst_in)
      if (rst_in)
         swr_len <= 4'h0;
      else
         swr_len <= sw_reset_out ? swr_len + 4'h1 : 4'h0;

   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);

   sequence s_swr_req;
      wr && wb_adr_in == ADR_PROC_MODE0 && wb_sel_in[0] && wb_dat_in[SW_RESET_BIT];
   endsequence
   sequence s_swr_pulse;
      sw_reset_out [*8];
   endsequence

   // ====
   // Assertions
   ack_follows_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack missing one cycle after request");
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   swr_start_a: assert property (s_swr_req |=> s_swr_pulse)
      else $error("software reset pulse not started");
   swr_width_a: assert property (!sw_reset_out && swr_len != 4'h0 |-> swr_len == SWRST_CYCLES)
      else $error("software reset pulse width wrong");
   swr_cause_a: assert property ($rose(sw_reset_out) |-> $past(wr) && $past(wb_adr_in) == ADR_PROC_MODE0)
      else $error("software reset pulse without request");
   irq_off_a: assert property (irq_off |=> ##1 !irq_out)
      else $error("interrupt not removed by clear or mask");
   irq_sticky_a: assert property ($fell(irq_out) |-> $past(irq_off, 2))
      else $error("interrupt dropped on its own");
   irq_status_a: assert property (rd && wb_adr_in == ADR_IRQ_STATUS && irq_out |-> wb_dat_out[0])
      else $error("interrupt high with status clear");
   cnt_top_a: assert property (rd && wb_adr_in == ADR_RESTART |-> wb_dat_out[CNT_MSB] && wb_dat_out[31:12] == 20'h00000)
      else $error("counter read below reload point");
   rel_pulse_a: assert property (stop_release_out |=> !stop_release_out)
      else $error("stop release longer than one cycle");
   unmapped_read_a: assert property (rd && (wb_adr_in == ADR_PROC_MODE0 || wb_adr_in > ADR_IRQ_ENABLE) |-> wb_dat_out == 32'h0)
      else $error("unmapped or write-only read not zero");
endmodule

bind rwd_watchdog rwd_watchdog_asserts u_chk (.clock_in(clock_in), .rst_in(rst_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .irq_out(irq_out), .sw_reset_out(sw_reset_out), .stop_release_out(stop_release_out));

/* File: testbench/rwd_watchdog_test.sv */
/* Self-checking bench for rwd_watchdog.
   Assumes the checker file is compiled with it; one 10 MHz clock. */
`timescale 1ns/1ns
module rwd_watchdog_test;
   import rwd_pkg::*;
   logic                clock_in = 1'b0;
   logic                rst_in = 1'b1;
   logic                cyc = 1'b0;
   logic                stb = 1'b0;
   logic                we = 1'b0;
   logic [WB_ADR_W-1:0] adr = 8'h00;
   logic [3:0]          sel = 4'hf;
   logic [WB_DAT_W-1:0] dat_w = 32'h0;
   logic [WB_DAT_W-1:0] dat_r;
   logic [WB_DAT_W-1:0] q;
   logic                ack, irq, swr, rel;
   logic                stop_i = 1'b0;
   logic                wake_i = 1'b0;
   logic                hold_i = 1'b0;
   logic                dis_i = 1'b0;
   int                  fail_count = 0;
   int                  checks = 0;
   int                  rel_seen = 0;
   int                  n;
   logic [31:0]         ext_cfg [4] = '{32'h02, 32'h12, 32'h24, 32'h22};
   int                  ext_len [4] = '{160, 160, 160, 320};

   always #50 clock_in = ~clock_in;

   rwd_watchdog dut (.clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
      .wb_ack_out(ack), .stop_instruction_in(stop_i), .stop_wake_in(wake_i), .hold_in(hold_i),
      .wdt_disable_in(dis_i), .irq_out(irq), .sw_reset_out(swr), .stop_release_out(rel));

   always @(posedge clock_in)
      if (rel === 1'b1)
         rel_seen++;

   // ====
   // Shared tasks
   task final_report;
      $display("fail_count=%0d checks=%0d", fail_count, checks);
      if (fail_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Classic single cycle; the slave decides when ack comes
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do @(posedge clock_in); while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // Restart, then count ticks over len clocks; read spacing adds under 8 clocks
   task rate(input int len, input int lo, input int hi, input string name);
      int d;
      logic [11:0] a;
      xfer(1'b1, ADR_RESTART, 32'h0);
      xfer(1'b0, ADR_RESTART, 32'h0);
      a = q[11:0];
      repeat (len) @(posedge clock_in);
      xfer(1'b0, ADR_RESTART, 32'h0);
      d = int'(a) - int'(q[11:0]);
      checks++;
      if (d < lo || d > hi)
      begin
         fail_count++;
         $display("BAD %s expected %0d seen %0d", name, lo, d);
      end
   endtask

   task pulse_stop;
      @(posedge clock_in);
      stop_i <= 1'b1;
      @(posedge clock_in);
      stop_i <= 1'b0;
   endtask

   // ====
   // Scenarios
   task t_reset;
      xfer(1'b0, ADR_FREQ_SEL, 32'h0);
      check("freq flag", 32'h0, q);
      xfer(1'b0, ADR_IRQ_STATUS, 32'h0);
      check("status", 32'h0, q);
      xfer(1'b0, 8'h40, 32'h0);
      check("unmapped", 32'h0, q);
      xfer(1'b0, ADR_RESTART, 32'h0);
      check("count top", 32'h1, {31'h0, q[11]});
   endtask

   task t_rates;
      rate(2048, 4, 5, "div512");
      xfer(1'b1, ADR_FREQ_SEL, 32'h1);
      rate(320, 10, 11, "div32");
      xfer(1'b1, ADR_RESTART, 32'h0000_0123);
      xfer(1'b0, ADR_RESTART, 32'h0);
      check("restart load", 32'hff, {24'h0, q[11:4]});
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b1, ADR_CLK_CTRL, ext_cfg[i]);
         rate(ext_len[i], 10, 11, "ext clock");
      end
      xfer(1'b1, ADR_CLK_CTRL, 32'h0);
   endtask

   // Pins pass a synchroniser, so each change is given four clocks to land
   task t_freeze;
      hold_i <= 1'b1;
      repeat (4) @(posedge clock_in);
      rate(320, 0, 0, "hold");
      hold_i <= 1'b0;
      dis_i <= 1'b1;
      repeat (4) @(posedge clock_in);
      rate(320, 0, 0, "disable");
      dis_i <= 1'b0;
      repeat (4) @(posedge clock_in);
   endtask

   task t_stop;
      xfer(1'b1, ADR_IRQ_ENABLE, 32'h1);
      xfer(1'b1, ADR_FREQ_SEL, 32'h0);
      xfer(1'b1, ADR_CLK_CTRL, 32'h1);
      pulse_stop();
      rate(80, 10, 11, "stop div8");
      n = 0;
      while (irq !== 1'b1 && n < 20000)
      begin
         @(posedge clock_in);
         n++;
      end
      check("irq raised", 32'h1, {31'h0, irq});
      check("release", 32'h1, rel_seen);
      xfer(1'b0, ADR_IRQ_STATUS, 32'h0);
      check("status set", 32'h1, q);
      xfer(1'b0, ADR_RESTART, 32'h0);
      check("reload", 32'hf, {28'h0, q[11:8]});
      repeat (20) @(posedge clock_in);
      check("irq held", 32'h1, {31'h0, irq});
      xfer(1'b1, ADR_IRQ_ENABLE, 32'h0);
      repeat (2) @(posedge clock_in);
      check("irq masked", 32'h0, {31'h0, irq});
      xfer(1'b1, ADR_IRQ_ENABLE, 32'h1);
      repeat (2) @(posedge clock_in);
      check("irq unmasked", 32'h1, {31'h0, irq});
      xfer(1'b1, ADR_IRQ_CLEAR, 32'h1);
      repeat (2) @(posedge clock_in);
      check("irq cleared", 32'h0, {31'h0, irq});
      xfer(1'b1, ADR_CLK_CTRL, 32'h0);
      pulse_stop();
      rate(320, 10, 11, "stop div32");
      @(posedge clock_in);
      wake_i <= 1'b1;
      @(posedge clock_in);
      wake_i <= 1'b0;
      rate(2048, 4, 5, "after wake");
   endtask

   task t_swr;
      xfer(1'b1, ADR_PROC_MODE0, 32'h7);
      repeat (5) @(posedge clock_in);
      check("no reset pulse", 32'h0, {31'h0, swr});
      xfer(1'b1, ADR_PROC_MODE0, 32'h8);
      n = 0;
      while (swr !== 1'b1 && n < 5)
      begin
         @(posedge clock_in);
         n++;
      end
      n = 0;
      while (swr === 1'b1 && n < 50)
      begin
         @(posedge clock_in);
         n++;
      end
      check("reset width", SWRST_CYCLES, n);
   endtask

   initial
   begin
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      t_reset();
      t_rates();
      t_freeze();
      t_stop();
      t_swr();
      final_report();
   end

   // Whole run needs about 25000 clocks
   initial
   begin
      repeat (40000) @(posedge clock_in);
      fail_count++;
      $display("BAD watchdog expected done seen hang");
      final_report();
   end
endmodule
